// ==== bench/ulpi_link_model.sv ====
// link controller model issuing ulpi register accesses
`timescale 1ns/1ps
module ulpi_link_model (
    input wire logic clk,
    output ulpi_vendor_pkg::reg_req_t req,
    input ulpi_vendor_pkg::reg_rsp_t rsp
);
    int gap = 0;
    initial req = '0;
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic release_bus();
        req <= '{rd: 1'b0, wr: 1'b0, ext: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
    endtask : release_bus
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] wd;
        wd = data;
        if (addr == 8'h36 || addr == 8'h37) begin
            wd[5] = 1'b0;
        end
        repeat (gap) @(posedge clk);
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, ext: 1'b0, addr: addr, wdata: wd};
        @(posedge clk);
        release_bus();
    endtask : wr
    task automatic rd(input logic ext, input logic [7:0] addr,
                      output ulpi_vendor_pkg::reg_rsp_t r);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, ext: ext, addr: addr, wdata: ~req.wdata};
        @(posedge clk);
        release_bus();
        @(posedge clk);
        r = rsp;
    endtask : rd
endmodule : ulpi_link_model

// ==== bench/ulpi_phy_vendor_registers_tb.sv ====
// self-checking bench of the ulpi vendor register bank
`timescale 1ns/1ps
module ulpi_phy_vendor_registers_tb;
    localparam int CONV = 20;
    logic clk;
    logic rstN;
    ulpi_vendor_pkg::reg_req_t req;
    ulpi_vendor_pkg::reg_rsp_t rsp;
    logic [2:0] sense;
    logic carkitEn;
    logic uartMode;
    logic txEn;
    ulpi_vendor_pkg::analog_ctrl_t ctrl;
    logic [2:0] code;
    logic done;
    logic altInt;
    logic latchSet;
    int numErrors = 0;
    int cmpCount = 0;
    int irqCount = 0;
    int latchCount = 0;
    ulpi_vendor_pkg::reg_rsp_t r;
    // write addr, write data, read addr, expected read
    logic [31:0] rows [11] = '{32'h31FF_3160, 32'h3140_3140, 32'h33FA_330A,
        32'h39FF_3AFE, 32'h3B0C_3BF2, 32'h3A01_39F2, 32'h3647_3747, 32'h3840_3807,
        32'h3780_3607, 32'h30FF_3000, 32'h32FF_3200};
    logic [15:0] rstRows [4] = '{16'h3100, 16'h3300, 16'h3600, 16'h3904};
    ulpi_phy_vendor_registers #(.CONV_CYCLES(CONV)) uut (
        .clk(clk),
        .rst_n(rstN),
        .req(req),
        .rsp(rsp),
        .idResistorSense(sense),
        .carkitRidIntEnable(carkitEn),
        .uartMode(uartMode),
        .serialTransmitEnable(txEn),
        .ctrl(ctrl),
        .idResistorCode(code),
        .idConversionDone(done),
        .altInt(altInt),
        .idConversionLatchSet(latchSet)
    );
    ulpi_link_model link (
        .clk(clk),
        .req(req),
        .rsp(rsp)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (altInt === 1'b1) begin
            irqCount++;
        end
        if (latchSet === 1'b1) begin
            latchCount++;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmpCount++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            numErrors++;
        end
    endtask : chk
    task automatic conclude();
        if (numErrors == 0 && cmpCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic do_reset();
        @(posedge clk);
        rstN <= 1'b0;
        repeat (8) @(posedge clk);
        rstN <= 1'b1;
    endtask : do_reset
    task automatic run_conv(input logic [2:0] s, input logic ck, input logic [7:0] setVal,
                            input int expIrq, input logic [7:0] expRd);
        int n;
        @(posedge clk);
        sense <= s;
        carkitEn <= ck;
        repeat (6) @(posedge clk);
        link.wr(8'h37, setVal);
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) begin
            numErrors++;
            conclude();
        end
        chk("conv time", 8'h01, {7'h00, n >= CONV && n <= CONV + 6});
        repeat (4) @(posedge clk);
        #1;
        chk("done held", 8'h01, done);
        chk("code out", {5'h00, s}, code);
        link.rd(1'b0, 8'h36, r);
        chk("conv read", expRd, r.data);
        link.rd(1'b0, 8'h38, r);
        chk("conv reread", expRd & 8'hF7, r.data);
        chk("done out", 8'h00, done);
        chk("irq pulses", 8'(expIrq), 8'(irqCount));
        chk("latch pulses", 8'(expIrq), 8'(latchCount));
    endtask : run_conv
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstN = 1'b0;
        sense = 3'b000;
        carkitEn = 1'b0;
        uartMode = 1'b0;
        txEn = 1'b0;
        do_reset();
        for (int i = 0; i < 11; i++) begin
            link.wr(rows[i][31:24], rows[i][23:16]);
            link.rd(1'b0, rows[i][15:8], r);
            chk("valid", 8'h01, r.valid);
            chk("readback", rows[i][7:0], r.data);
        end
        do_reset();
        for (int i = 0; i < 4; i++) begin
            link.rd(1'b0, rstRows[i][15:8], r);
            chk("reset value", rstRows[i][7:0], r.data);
        end
        link.wr(8'h31, 8'h60);
        link.wr(8'h33, 8'h0A);
        link.wr(8'h39, 8'h5A);
        settle();
        chk("boost", 8'h03, ctrl.boostLevel);
        chk("audio on", 8'h01, ctrl.headsetAudioEnable);
        chk("swap", 8'h01, ctrl.linePairSwap);
        chk("pullup plus", 8'h01, ctrl.chargerPullupPlus);
        chk("pullup minus", 8'h00, ctrl.chargerPullupMinus);
        chk("usb level", 8'h01, ctrl.regulatorLevel);
        @(posedge clk);
        uartMode <= 1'b1;
        settle();
        chk("uart pullup", 8'h01, ctrl.chargerPullupMinus);
        chk("level no txd", 8'h01, ctrl.regulatorLevel);
        @(posedge clk);
        txEn <= 1'b1;
        settle();
        chk("uart level", 8'h02, ctrl.regulatorLevel);
        link.wr(8'h33, 8'h0B);
        settle();
        chk("audio off", 8'h00, ctrl.headsetAudioEnable);
        @(posedge clk);
        uartMode <= 1'b0;
        txEn <= 1'b0;
        link.rd(1'b1, 8'h39, r);
        chk("ext read", 8'h5A, r.data);
        link.rd(1'b0, 8'hF9, r);
        chk("imm read", 8'h5A, r.data);
        link.rd(1'b1, 8'h79, r);
        chk("ext unmapped hit", 8'h00, r.hit);
        chk("ext unmapped data", 8'h00, r.data);
        link.gap = 2;
        run_conv(3'b101, 1'b0, 8'h50, 1, 8'h4D);
        link.wr(8'h38, 8'h40);
        run_conv(3'b111, 1'b1, 8'h10, 2, 8'h0F);
        run_conv(3'b010, 1'b0, 8'h10, 2, 8'h0A);
        conclude();
    end
endmodule : ulpi_phy_vendor_registers_tb

// ==== hw/id_conv_timer.sv ====
// id resistor conversion timer and result capture
`timescale 1ns/1ps
module id_conv_timer #(
    parameter int CYCLES = ulpi_vendor_pkg::CONV_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic launch,
    input wire logic [2:0] sampleCode,
    output logic busy,
    output logic done,
    output logic [2:0] code
);
    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [31:0] count_r;
    wire lastCycle = (count_r == 32'(CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            code <= 3'h0;
            count_r <= 32'h0;
        end else begin
            done <= 1'b0;
            if (launch) begin
                busy <= 1'b1;
                count_r <= 32'h0;
            end else if (busy && lastCycle) begin
                busy <= 1'b0;
                done <= 1'b1;
                code <= sampleCode;
            end else if (busy) begin
                count_r <= count_r + 32'h1;
            end
        end
    end
endmodule : id_conv_timer

// ==== hw/ulpi_phy_vendor_registers.sv ====
// ulpi vendor register bank with id resistor conversion control
`timescale 1ns/1ps
module ulpi_phy_vendor_registers #(
    parameter int CONV_CYCLES = ulpi_vendor_pkg::CONV_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input ulpi_vendor_pkg::reg_req_t req,
    output ulpi_vendor_pkg::reg_rsp_t rsp,
    input wire logic [2:0] idResistorSense,
    input wire logic carkitRidIntEnable,
    input wire logic uartMode,
    input wire logic serialTransmitEnable,
    output ulpi_vendor_pkg::analog_ctrl_t ctrl,
    output logic [2:0] idResistorCode,
    output logic idConversionDone,
    output logic altInt,
    output logic idConversionLatchSet
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic ulpi_vendor_pkg::wr_op_t opFor(
        input logic [7:0] addr,
        input logic [7:0] base,
        input logic wr
    );
        ulpi_vendor_pkg::wr_op_t op;
        op = ulpi_vendor_pkg::OP_NONE;
        if (wr && addr == base) begin
            op = ulpi_vendor_pkg::OP_WRITE;
        end else if (wr && addr == base + ulpi_vendor_pkg::ADDR_SET_OFS) begin
            op = ulpi_vendor_pkg::OP_SET;
        end else if (wr && addr == base + ulpi_vendor_pkg::ADDR_CLR_OFS) begin
            op = ulpi_vendor_pkg::OP_CLEAR;
        end
        return op;
    endfunction : opFor

    function automatic logic [7:0] applyWr(
        input logic [7:0] cur,
        input logic [7:0] wd,
        input ulpi_vendor_pkg::wr_op_t op,
        input logic [7:0] mask
    );
        logic [7:0] v;
        v = cur;
        case (op)
            ulpi_vendor_pkg::OP_WRITE: v = wd;
            ulpi_vendor_pkg::OP_SET: v = cur | wd;
            ulpi_vendor_pkg::OP_CLEAR: v = cur & ~wd;
            default: v = cur;
        endcase
        return v & mask;
    endfunction : applyWr

    function automatic logic inGroup(input logic [7:0] addr, input logic [7:0] base);
        return addr >= base && addr <= base + ulpi_vendor_pkg::ADDR_CLR_OFS;
    endfunction : inGroup

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [7:0] boost_r;
    logic [7:0] audio_r;
    logic [7:0] conv_r;
    logic [7:0] iopm_r;
    logic doneFlag_r;

    wire [7:0] effAddr = req.ext ? req.addr : (req.addr & ulpi_vendor_pkg::ADDR_IMM_MASK);
    wire inVendor = effAddr >= ulpi_vendor_pkg::ADDR_VENDOR_LO
        && effAddr <= ulpi_vendor_pkg::ADDR_VENDOR_HI;
    wire wrBoost = req.wr && effAddr == ulpi_vendor_pkg::ADDR_BOOST;
    wire wrAudio = req.wr && effAddr == ulpi_vendor_pkg::ADDR_AUDIO;
    ulpi_vendor_pkg::wr_op_t opConv;
    ulpi_vendor_pkg::wr_op_t opIopm;
    assign opConv = opFor(effAddr, ulpi_vendor_pkg::ADDR_CONV, req.wr);
    assign opIopm = opFor(effAddr, ulpi_vendor_pkg::ADDR_IOPM, req.wr);
    wire selConv = inGroup(effAddr, ulpi_vendor_pkg::ADDR_CONV);
    wire selIopm = inGroup(effAddr, ulpi_vendor_pkg::ADDR_IOPM);
    wire readConv = req.rd && selConv;

    // ------------------------------------------------------------
    // id resistor sense synchroniser
    // ------------------------------------------------------------
    logic [2:0] senseS1_r;
    logic [2:0] senseS2_r;
    logic [2:0] senseS3_r;
    logic [2:0] senseStable_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            senseS1_r <= 3'h0;
            senseS2_r <= 3'h0;
            senseS3_r <= 3'h0;
            senseStable_r <= 3'h0;
        end else begin
            senseS1_r <= idResistorSense;
            senseS2_r <= senseS1_r;
            senseS3_r <= senseS2_r;
            if (senseS2_r == senseS3_r) begin
                senseStable_r <= senseS3_r;
            end
        end
    end

    // ------------------------------------------------------------
    // conversion timer
    // ------------------------------------------------------------
    logic timerBusy;
    logic timerDone;
    logic [2:0] timerCode;
    wire launch = conv_r[ulpi_vendor_pkg::CONV_START] && !timerBusy && !timerDone;

    id_conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .launch(launch),
        .sampleCode(senseStable_r),
        .busy(timerBusy),
        .done(timerDone),
        .code(timerCode)
    );

    // ------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------
    wire [7:0] convWr = applyWr(conv_r, req.wdata, opConv, ulpi_vendor_pkg::CONV_MASK);
    wire [7:0] conv_nxt = timerDone
        ? {convWr[7:5], 1'b0, convWr[3], timerCode}
        : convWr;
    // only a vendor-side read clears; carkit status reads are not seen here
    wire doneFlag_nxt = timerDone | (doneFlag_r & ~readConv);
    wire doneRise = doneFlag_nxt & ~doneFlag_r;
    wire effIrqEnable = conv_r[ulpi_vendor_pkg::CONV_IEN] | carkitRidIntEnable;
    wire [7:0] iopm_nxt = applyWr(iopm_r, req.wdata, opIopm, ulpi_vendor_pkg::IOPM_MASK);
    wire [7:0] boost_nxt = wrBoost
        ? (req.wdata & ulpi_vendor_pkg::BOOST_MASK) : boost_r;
    wire [7:0] audio_nxt = wrAudio
        ? (req.wdata & ulpi_vendor_pkg::AUDIO_MASK) : audio_r;
    wire uartActive = uartMode && serialTransmitEnable;
    wire [1:0] uartLevel = iopm_r[ulpi_vendor_pkg::IOPM_UART_LSB +: 2];
    wire [1:0] usbLevel = iopm_r[ulpi_vendor_pkg::IOPM_USB_LSB +: 2];
    wire [7:0] convRead = {conv_r[7:4], doneFlag_r, conv_r[2:0]};

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [7:0] readData = selConv ? convRead
        : selIopm ? iopm_r
        : effAddr == ulpi_vendor_pkg::ADDR_BOOST ? boost_r
        : effAddr == ulpi_vendor_pkg::ADDR_AUDIO ? audio_r
        : 8'h00;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boost_r <= ulpi_vendor_pkg::BOOST_RST;
            audio_r <= ulpi_vendor_pkg::AUDIO_RST;
            conv_r <= ulpi_vendor_pkg::CONV_RST;
            iopm_r <= ulpi_vendor_pkg::IOPM_RST;
            doneFlag_r <= 1'b0;
        end else begin
            boost_r <= boost_nxt;
            audio_r <= audio_nxt;
            conv_r <= conv_nxt;
            iopm_r <= iopm_nxt;
            doneFlag_r <= doneFlag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp <= '0;
            altInt <= 1'b0;
            idConversionLatchSet <= 1'b0;
        end else begin
            rsp.valid <= req.rd;
            rsp.hit <= req.rd && inVendor;
            rsp.data <= req.rd ? readData : 8'h00;
            altInt <= doneRise && effIrqEnable;
            idConversionLatchSet <= doneRise && effIrqEnable;
        end
    end

    // ------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= '0;
            idResistorCode <= 3'h0;
            idConversionDone <= 1'b0;
        end else begin
            ctrl.boostLevel <= boost_r[ulpi_vendor_pkg::BOOST_LSB +: 2];
            ctrl.headsetAudioEnable <= audio_r[3:0] == ulpi_vendor_pkg::AUDIO_KEY;
            ctrl.linePairSwap <= iopm_r[ulpi_vendor_pkg::IOPM_SWAP];
            ctrl.chargerPullupPlus <= iopm_r[ulpi_vendor_pkg::IOPM_PU_PLUS] | uartMode;
            ctrl.chargerPullupMinus <= iopm_r[ulpi_vendor_pkg::IOPM_PU_MINUS] | uartMode;
            ctrl.regulatorLevel <= uartActive ? uartLevel : usbLevel;
            idResistorCode <= conv_r[2:0];
            idConversionDone <= doneFlag_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [31:0] sinceLaunch_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sinceLaunch_r <= 32'h0;
        end else begin
            sinceLaunch_r <= launch ? 32'h1 : sinceLaunch_r + 32'h1;
        end
    end

    property p_conv_time;
        @(posedge clk) disable iff (!rst_n)
        timerDone |-> sinceLaunch_r == 32'(CONV_CYCLES + 1);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

    property p_done_sets;
        @(posedge clk) disable iff (!rst_n)
        timerDone |=> doneFlag_r && !conv_r[ulpi_vendor_pkg::CONV_START];
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done or start wrong");

    property p_read_clears;
        @(posedge clk) disable iff (!rst_n)
        readConv && !timerDone |=> !doneFlag_r;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("done not cleared");

    property p_alt_int;
        @(posedge clk) disable iff (!rst_n)
        altInt == ($rose(doneFlag_r)
            && $past(conv_r[ulpi_vendor_pkg::CONV_IEN] | carkitRidIntEnable));
    endproperty
    a_alt_int: assert property (p_alt_int) else $error("alt_int mismatch");

    property p_headset;
        @(posedge clk) disable iff (!rst_n)
        wrAudio |=> ##1 ctrl.headsetAudioEnable == ($past(req.wdata[3:0], 2) == 4'hA);
    endproperty
    a_headset: assert property (p_headset) else $error("headset key decode wrong");

    property p_iopm_set;
        @(posedge clk) disable iff (!rst_n)
        opIopm == ulpi_vendor_pkg::OP_SET
        |=> iopm_r == (($past(iopm_r) | $past(req.wdata)) & 8'hFE);
    endproperty
    a_iopm_set: assert property (p_iopm_set) else $error("set access wrong");

    property p_uart_pullup;
        @(posedge clk) disable iff (!rst_n)
        uartMode |=> ctrl.chargerPullupPlus && ctrl.chargerPullupMinus;
    endproperty
    a_uart_pullup: assert property (p_uart_pullup) else $error("uart pull-up off");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        !iopm_r[0] && !conv_r[7] && !boost_r[7] && audio_r[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_regulator;
        @(posedge clk) disable iff (!rst_n)
        uartActive |=> ctrl.regulatorLevel == $past(iopm_r[3:2]);
    endproperty
    a_regulator: assert property (p_regulator) else $error("uart regulator level wrong");

    property p_latch;
        @(posedge clk) disable iff (!rst_n)
        idConversionLatchSet == ($rose(doneFlag_r)
            && $past(conv_r[ulpi_vendor_pkg::CONV_IEN] | carkitRidIntEnable));
    endproperty
    a_latch: assert property (p_latch) else $error("latch pulse mismatch");

    property p_boost;
        @(posedge clk) disable iff (!rst_n)
        wrBoost |=> ##1
            ctrl.boostLevel == $past(req.wdata[ulpi_vendor_pkg::BOOST_LSB +: 2], 2);
    endproperty
    a_boost: assert property (p_boost) else $error("boost level wrong");

    property p_iopm_clear;
        @(posedge clk) disable iff (!rst_n)
        opIopm == ulpi_vendor_pkg::OP_CLEAR
        |=> iopm_r == ($past(iopm_r) & ~$past(req.wdata) & ulpi_vendor_pkg::IOPM_MASK);
    endproperty
    a_iopm_clear: assert property (p_iopm_clear) else $error("clear access wrong");

    property p_conv_set;
        @(posedge clk) disable iff (!rst_n)
        opConv == ulpi_vendor_pkg::OP_SET && !timerDone
        |=> conv_r == (($past(conv_r) | $past(req.wdata)) & ulpi_vendor_pkg::CONV_MASK);
    endproperty
    a_conv_set: assert property (p_conv_set) else $error("conversion set wrong");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        req.rd && !inVendor |=> rsp.valid && !rsp.hit && rsp.data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

    property p_launch;
        @(posedge clk) disable iff (!rst_n)
        launch |=> timerBusy;
    endproperty
    a_launch: assert property (p_launch) else $error("conversion not started");
endmodule : ulpi_phy_vendor_registers

// ==== pkg/ulpi_vendor_pkg.sv ====
// constants and types of the ulpi vendor register bank
// Functional notes
// - immediate registers answer both immediate and extended addresses
// - vendor range is 30h to 3Fh, reached by immediate reads and writes
// - boost bits 6:5: 00 nominal, 01 reserved, 10 +7.4%, 11 +3.7%
// - headset audio mode on only while key bits 3:0 hold 1010
// - id code bits 2:0 report measured resistor class, 111 is error
// - done flag bit 3 sets when a 282 us conversion ends
// - reading the conversion register clears the done flag
// - reading code through carkit status leaves done flag untouched
// - start bit 4 launches conversion, clears itself on completion
// - with irq enable bit 6 set, done rising raises alt_int
// - effective irq enable is this bit ORed with carkit enable bit
// - conversion register: write 36h, set 37h, clear 38h, read all three
// - io power register: write 39h, set 3Ah, clear 3Bh, read all three
// - swap bit 1 exchanges data pins, in uart mode too
// - uart regulator level bits 3:2, default 01, used once transmit enabled
// - bits 4 and 5 connect charger pull-up to plus or minus pin
// - uart mode forces both data-pin pull-ups on
// - usb regulator level bits 7:6, default 00, used unless uart mode has transmit enabled
// - enabled done rising sets the carkit conversion latch
package ulpi_vendor_pkg;
    // ------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_VENDOR_LO = 8'h30;
    localparam logic [7:0] ADDR_VENDOR_HI = 8'h3F;
    localparam logic [7:0] ADDR_IMM_MASK = 8'h3F;
    localparam logic [7:0] ADDR_BOOST = 8'h31;
    localparam logic [7:0] ADDR_AUDIO = 8'h33;
    localparam logic [7:0] ADDR_CONV = 8'h36;
    localparam logic [7:0] ADDR_IOPM = 8'h39;
    localparam logic [7:0] ADDR_SET_OFS = 8'h01;
    localparam logic [7:0] ADDR_CLR_OFS = 8'h02;
    // ------------------------------------------------------------
    // fields and masks
    // ------------------------------------------------------------
    localparam logic [7:0] BOOST_MASK = 8'h60;
    localparam logic [7:0] AUDIO_MASK = 8'h0F;
    localparam logic [7:0] CONV_MASK = 8'h77;
    localparam logic [7:0] IOPM_MASK = 8'hFE;
    localparam int BOOST_LSB = 5;
    localparam int CONV_DONE = 3;
    localparam int CONV_START = 4;
    localparam int CONV_IEN = 6;
    localparam int IOPM_SWAP = 1;
    localparam int IOPM_UART_LSB = 2;
    localparam int IOPM_PU_PLUS = 4;
    localparam int IOPM_PU_MINUS = 5;
    localparam int IOPM_USB_LSB = 6;
    localparam logic [3:0] AUDIO_KEY = 4'hA;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BOOST_RST = 8'h00;
    localparam logic [7:0] AUDIO_RST = 8'h00;
    localparam logic [7:0] CONV_RST = 8'h00;
    localparam logic [7:0] IOPM_RST = 8'h04;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CONV_TIME_NS = 282000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_WRITE = 2'b01,
        OP_SET = 2'b10,
        OP_CLEAR = 2'b11
    } wr_op_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic ext;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic valid;
        logic hit;
        logic [7:0] data;
    } reg_rsp_t;
    typedef struct packed {
        logic [1:0] boostLevel;
        logic headsetAudioEnable;
        logic linePairSwap;
        logic chargerPullupPlus;
        logic chargerPullupMinus;
        logic [1:0] regulatorLevel;
    } analog_ctrl_t;
endpackage : ulpi_vendor_pkg
